// *** hw/shp_defines.svh ***
// register offsets, field positions, reset values and timing of the port
`ifndef SHP_DEFINES_SVH
`define SHP_DEFINES_SVH

// ************************************************************
// clock and line timing
// ************************************************************
`define SHP_CLK_HZ 25000000
`define SHP_OVS 16
`define SHP_BAUD_0 1200
`define SHP_BAUD_1 2400
`define SHP_BAUD_2 4800
`define SHP_BAUD_3 9600
`define SHP_FRAME_BITS 11
`define SHP_STOP_BITS 2

// ************************************************************
// buffer sizing and special characters
// ************************************************************
`define SHP_RX_DEPTH 128
`define SHP_RX_FULL 100
`define SHP_CH_NL 8'h0a
`define SHP_CH_ETX 8'h03

// ************************************************************
// register byte offsets
// ************************************************************
`define SHP_ADR_CTRL 8'h00
`define SHP_ADR_STAT 8'h04
`define SHP_ADR_RXDATA 8'h08
`define SHP_ADR_TXDATA 8'h0c
`define SHP_ADR_TALK 8'h10
`define SHP_ADR_IRQ_STAT 8'h14
`define SHP_ADR_IRQ_MASK 8'h18

// ************************************************************
// control fields and reset value
// ************************************************************
`define SHP_CTRL_BAUD_LSB 0
`define SHP_CTRL_SEVEN 2
`define SHP_CTRL_ODD 3
`define SHP_CTRL_RST 4'h3
`define SHP_TX_LAST 8

// ************************************************************
// interrupt status bits
// ************************************************************
`define SHP_IRQ_W 6
`define SHP_IRQ_RX 0
`define SHP_IRQ_FRAME 1
`define SHP_IRQ_PARITY 2
`define SHP_IRQ_BREAK 3
`define SHP_IRQ_DONE 4
`define SHP_IRQ_OVER 5

`endif

// *** hw/shp_pkg.sv ***
// shared types of the serial port
package shp_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} shp_rx_e;
  typedef enum logic {TX_IDLE, TX_SEND} shp_tx_e;
  typedef logic [7:0] shp_byte_t;
endpackage

// *** hw/shp_rx.sv ***
// receive deserialiser: 16x oversampled, framing and parity check
`timescale 1ns/1ps
`default_nettype none
`include "shp_defines.svh"

module shp_rx
  import shp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic rxd_i,
  input wire logic seven_i,
  input wire logic odd_i,
  output logic valid_o,
  output shp_byte_t data_o,
  output logic frame_err_o,
  output logic parity_err_o
);

  shp_rx_e st_ff, nxt_st; // receiver state
  logic [3:0] tck_ff, nxt_tck; // oversample tick count
  logic [3:0] bit_ff, nxt_bit; // bit index in phase
  shp_byte_t sh_ff, nxt_sh; // data shifter, lsb first
  logic prev_ff, nxt_prev; // line level one clock ago
  logic ferr_ff, nxt_ferr; // low stop bit seen
  logic valid_ff, nxt_valid;
  shp_byte_t data_ff, nxt_data;
  logic fout_ff, nxt_fout;
  logic pout_ff, nxt_pout;

  // ************************************************************
  // next state of the receiver
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_tck = tck_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_prev = rxd_i;
    nxt_ferr = ferr_ff;
    nxt_valid = 1'b0;
    nxt_data = data_ff;
    nxt_fout = fout_ff;
    nxt_pout = pout_ff;
    unique case (st_ff)
      RX_IDLE: begin
        // falling edge of the start bit
        if (prev_ff && !rxd_i) begin
          nxt_st = RX_START;
          nxt_tck = 4'h0;
        end
      end
      RX_START: begin
        if (tick_i) begin
          nxt_tck = tck_ff + 4'h1;
          // half a bit in: confirm start, else glitch
          if (tck_ff == 4'h7) begin
            nxt_tck = 4'h0;
            nxt_bit = 4'h0;
            nxt_ferr = 1'b0;
            nxt_st = rxd_i ? RX_IDLE : RX_BITS;
          end
        end
      end
      RX_BITS: begin
        if (tick_i) begin
          nxt_tck = tck_ff + 4'h1;
          // centre sample of each of eight data slots
          if (tck_ff == 4'hf) begin
            nxt_sh = {rxd_i, sh_ff[7:1]};
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              nxt_bit = 4'h0;
              nxt_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick_i) begin
          nxt_tck = tck_ff + 4'h1;
          if (tck_ff == 4'hf) begin
            // both stop bits must be high
            nxt_ferr = ferr_ff | !rxd_i;
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'(`SHP_STOP_BITS - 1)) begin
              nxt_st = RX_IDLE;
              nxt_valid = 1'b1;
              nxt_fout = ferr_ff | !rxd_i;
              // seven bits plus parity, or eight plain
              nxt_data = seven_i ? {1'b0, sh_ff[6:0]} : sh_ff;
              nxt_pout = seven_i & ((^sh_ff) != odd_i);
            end
          end
        end
      end
    endcase
  end

  // ************************************************************
  // receiver registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= RX_IDLE;
      tck_ff <= 4'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      prev_ff <= 1'b1;
      ferr_ff <= 1'b0;
      valid_ff <= 1'b0;
      data_ff <= 8'h00;
      fout_ff <= 1'b0;
      pout_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tck_ff <= nxt_tck;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      prev_ff <= nxt_prev;
      ferr_ff <= nxt_ferr;
      valid_ff <= nxt_valid;
      data_ff <= nxt_data;
      fout_ff <= nxt_fout;
      pout_ff <= nxt_pout;
    end
  end

  assign valid_o = valid_ff;
  assign data_o = data_ff;
  assign frame_err_o = fout_ff;
  assign parity_err_o = pout_ff;

endmodule // shp_rx

`default_nettype wire

// *** hw/shp_serial_port.sv ***
// serial programming port with dtr/dsr holdoff and wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "shp_defines.svh"

// Functional notes
// - eleven bit frame, one start, two stops
// - seven data plus parity, or eight
// - four rates: 1200, 2400, 4800, 9600
// - dtr false near 100 buffered chars
// - dtr false while answering a query
// - check dsr before each outgoing char
// - dtr false while output held by dsr
// - control-c clears work and pending output
// - every response ends with one newline
module shp_serial_port
  import shp_pkg::*;
#(
  parameter int RX_DEPTH = `SHP_RX_DEPTH,
  parameter int RX_FULL = `SHP_RX_FULL
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic dsr_i,
  output logic txd_o,
  output logic dtr_o,
  output logic irq_o
);

  localparam int AW = $clog2(RX_DEPTH); // buffer pointer width
  localparam int CW = AW + 1; // buffer count width

  // ************************************************************
  // shared decoding
  // ************************************************************

  // oversample divisor for a rate code
  function automatic logic [10:0] baud_div(input logic [1:0] sel);
    unique case (sel)
      2'h0: baud_div = 11'(`SHP_CLK_HZ / (`SHP_BAUD_0 * `SHP_OVS));
      2'h1: baud_div = 11'(`SHP_CLK_HZ / (`SHP_BAUD_1 * `SHP_OVS));
      2'h2: baud_div = 11'(`SHP_CLK_HZ / (`SHP_BAUD_2 * `SHP_OVS));
      2'h3: baud_div = 11'(`SHP_CLK_HZ / (`SHP_BAUD_3 * `SHP_OVS));
    endcase
  endfunction

  // start, data or parity, two stops, lsb first
  function automatic logic [10:0] frame(input shp_byte_t b,
                                        input logic seven,
                                        input logic odd);
    shp_byte_t d;
    d = seven ? {(^b[6:0]) ^ odd, b[6:0]} : b;
    frame = {2'b11, d, 1'b0};
  endfunction

  // ************************************************************
  // state declarations
  // ************************************************************
  logic [3:0] ctrl_ff, nxt_ctrl; // rate, width, parity sense
  logic ack_ff, nxt_ack; // bus acknowledge
  logic [31:0] dat_ff, nxt_dat; // registered read data
  logic [`SHP_IRQ_W-1:0] ist_ff, nxt_ist; // sticky events
  logic [`SHP_IRQ_W-1:0] imask_ff, nxt_imask; // event enables
  logic irq_ff, nxt_irq; // interrupt line
  logic [10:0] div_ff, nxt_div; // oversample divider
  logic tick_ff, nxt_tick; // 16x bit-rate enable
  shp_byte_t mem [RX_DEPTH]; // receive buffer
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt; // characters held
  shp_tx_e tst_ff, nxt_tst; // transmitter state
  logic [10:0] tsh_ff, nxt_tsh; // outgoing frame
  logic [3:0] ttk_ff, nxt_ttk; // tick within bit
  logic [3:0] tbit_ff, nxt_tbit; // bit within frame
  logic txd_ff, nxt_txd; // line driver
  shp_byte_t hold_ff, nxt_hold; // next response char
  logic hold_v_ff, nxt_hold_v; // holding slot full
  logic hold_last_ff, nxt_hold_last; // char ends response
  logic nlp_ff, nxt_nlp; // terminator owed
  logic snl_ff, nxt_snl; // frame on wire is terminator
  logic treq_ff, nxt_treq; // software finished a query
  logic nlseen_ff, nxt_nlseen; // newline arrived
  logic talk_ff, nxt_talk; // talk holdoff active
  logic dtr_ff, nxt_dtr; // holdoff line

  // ************************************************************
  // receiver and bus strobes
  // ************************************************************
  logic rx_valid, rx_ferr, rx_perr;
  shp_byte_t rx_data;
  logic take, wr, wr_tx, wr_talk, pop, push, brk, drop, rx_nl;
  logic resp_done, suspended;

  shp_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_ff),
    .rxd_i(rxd_i),
    .seven_i(ctrl_ff[`SHP_CTRL_SEVEN]),
    .odd_i(ctrl_ff[`SHP_CTRL_ODD]),
    .valid_o(rx_valid),
    .data_o(rx_data),
    .frame_err_o(rx_ferr),
    .parity_err_o(rx_perr)
  );

  // request decode and receive classification
  always_comb begin
    take = wb_cyc_i & wb_stb_i & !ack_ff;
    wr = take & wb_we_i & wb_sel_i[0];
    wr_tx = wr & (wb_adr_i == `SHP_ADR_TXDATA);
    wr_talk = wr & (wb_adr_i == `SHP_ADR_TALK) & wb_dat_i[0];
    pop = take & !wb_we_i & (wb_adr_i == `SHP_ADR_RXDATA) &
          (cnt_ff != '0);
    // control-c with good stop bits is a clear, never buffered
    brk = rx_valid & !rx_ferr & (rx_data == `SHP_CH_ETX);
    drop = rx_valid & !brk & (cnt_ff == CW'(RX_DEPTH));
    push = rx_valid & !brk & !drop;
    rx_nl = push & (rx_data == `SHP_CH_NL);
  end

  // ************************************************************
  // bit-rate divider
  // ************************************************************
  always_comb begin
    nxt_div = div_ff + 11'h001;
    nxt_tick = 1'b0;
    if (div_ff >= baud_div(ctrl_ff[1:0]) - 11'h001) begin
      nxt_div = 11'h000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 11'h000;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // ************************************************************
  // receive buffer
  // ************************************************************
  always_comb begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wp = wp_ff + AW'(1);
    end
    if (pop) begin
      nxt_rp = rp_ff + AW'(1);
    end
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
    // device clear also empties the input
    if (brk) begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_ff] <= rx_data;
    end
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // ************************************************************
  // transmitter
  // ************************************************************
  always_comb begin
    nxt_tst = tst_ff;
    nxt_tsh = tsh_ff;
    nxt_ttk = ttk_ff;
    nxt_tbit = tbit_ff;
    nxt_hold = hold_ff;
    nxt_hold_v = hold_v_ff;
    nxt_hold_last = hold_last_ff;
    nxt_nlp = nlp_ff;
    nxt_snl = snl_ff;
    resp_done = 1'b0;
    // software fills the slot only when it is empty
    if (wr_tx && !hold_v_ff) begin
      nxt_hold = wb_dat_i[7:0];
      nxt_hold_v = 1'b1;
      nxt_hold_last = wb_dat_i[`SHP_TX_LAST];
    end
    unique case (tst_ff)
      TX_IDLE: begin
        // dsr looked at before every character
        if ((hold_v_ff || nlp_ff) && dsr_i) begin
          nxt_tst = TX_SEND;
          nxt_ttk = 4'h0;
          nxt_tbit = 4'h0;
          nxt_snl = nlp_ff;
          if (nlp_ff) begin
            // single terminator after the last char
            nxt_tsh = frame(`SHP_CH_NL, ctrl_ff[`SHP_CTRL_SEVEN],
                            ctrl_ff[`SHP_CTRL_ODD]);
            nxt_nlp = 1'b0;
          end else begin
            nxt_tsh = frame(hold_ff, ctrl_ff[`SHP_CTRL_SEVEN],
                            ctrl_ff[`SHP_CTRL_ODD]);
            nxt_hold_v = 1'b0;
            nxt_nlp = hold_last_ff;
          end
        end
      end
      TX_SEND: begin
        if (tick_ff) begin
          nxt_ttk = ttk_ff + 4'h1;
          if (ttk_ff == 4'(`SHP_OVS - 1)) begin
            nxt_tsh = {1'b1, tsh_ff[10:1]};
            nxt_tbit = tbit_ff + 4'h1;
            // all eleven bits gone
            if (tbit_ff == 4'(`SHP_FRAME_BITS - 1)) begin
              nxt_tst = TX_IDLE;
              resp_done = snl_ff;
              nxt_snl = 1'b0;
            end
          end
        end
      end
    endcase
    // control-c discards pending output, wire frame ends cleanly
    if (brk) begin
      nxt_hold_v = 1'b0;
      nxt_nlp = 1'b0;
    end
    nxt_txd = (nxt_tst == TX_SEND) ? nxt_tsh[0] : 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tst_ff <= TX_IDLE;
      tsh_ff <= 11'h7ff;
      ttk_ff <= 4'h0;
      tbit_ff <= 4'h0;
      txd_ff <= 1'b1;
      hold_ff <= 8'h00;
      hold_v_ff <= 1'b0;
      hold_last_ff <= 1'b0;
      nlp_ff <= 1'b0;
      snl_ff <= 1'b0;
    end else begin
      tst_ff <= nxt_tst;
      tsh_ff <= nxt_tsh;
      ttk_ff <= nxt_ttk;
      tbit_ff <= nxt_tbit;
      txd_ff <= nxt_txd;
      hold_ff <= nxt_hold;
      hold_v_ff <= nxt_hold_v;
      hold_last_ff <= nxt_hold_last;
      nlp_ff <= nxt_nlp;
      snl_ff <= nxt_snl;
    end
  end

  // ************************************************************
  // holdoff line
  // ************************************************************
  always_comb begin
    nxt_treq = treq_ff | wr_talk;
    nxt_nlseen = nlseen_ff;
    nxt_talk = talk_ff;
    // talk once a query is done and its newline seen
    if (treq_ff && nlseen_ff) begin
      nxt_talk = 1'b1;
      nxt_treq = 1'b0;
      nxt_nlseen = 1'b0;
    end
    if (rx_nl) begin
      nxt_nlseen = 1'b1;
    end
    // released after the terminator leaves, or by a clear
    if (resp_done || brk) begin
      nxt_talk = 1'b0;
      nxt_treq = 1'b0;
    end
    // output waiting on a low dsr
    suspended = (tst_ff == TX_IDLE) & (hold_v_ff | nlp_ff) & !dsr_i;
    // full buffer, talking or suspended all hold off
    nxt_dtr = !((cnt_ff >= CW'(RX_FULL)) | talk_ff | suspended);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      treq_ff <= 1'b0;
      nlseen_ff <= 1'b0;
      talk_ff <= 1'b0;
      dtr_ff <= 1'b0;
    end else begin
      treq_ff <= nxt_treq;
      nlseen_ff <= nxt_nlseen;
      talk_ff <= nxt_talk;
      dtr_ff <= nxt_dtr;
    end
  end

  // ************************************************************
  // register file and interrupt
  // ************************************************************
  always_comb begin
    logic [`SHP_IRQ_W-1:0] ev;
    logic [`SHP_IRQ_W-1:0] clr;
    ev = '0;
    clr = '0;
    nxt_ctrl = ctrl_ff;
    nxt_imask = imask_ff;
    nxt_ack = take;
    nxt_dat = dat_ff;
    ev[`SHP_IRQ_RX] = push;
    ev[`SHP_IRQ_FRAME] = rx_valid & rx_ferr;
    ev[`SHP_IRQ_PARITY] = rx_valid & rx_perr;
    ev[`SHP_IRQ_BREAK] = brk;
    ev[`SHP_IRQ_DONE] = resp_done;
    ev[`SHP_IRQ_OVER] = drop;
    if (wr) begin
      unique case (wb_adr_i)
        `SHP_ADR_CTRL: nxt_ctrl = wb_dat_i[3:0];
        `SHP_ADR_IRQ_STAT: clr = wb_dat_i[`SHP_IRQ_W-1:0];
        `SHP_ADR_IRQ_MASK: nxt_imask = wb_dat_i[`SHP_IRQ_W-1:0];
        default: ;
      endcase
    end
    // a new event outweighs a clear in the same cycle
    nxt_ist = (ist_ff & ~clr) | ev;
    nxt_irq = |(nxt_ist & nxt_imask);
    if (take && !wb_we_i) begin
      unique case (wb_adr_i)
        `SHP_ADR_CTRL: nxt_dat = {28'h0000000, ctrl_ff};
        `SHP_ADR_STAT: nxt_dat = {19'h00000, hold_v_ff,
                                  tst_ff == TX_SEND, talk_ff, dsr_i,
                                  dtr_ff, 8'(cnt_ff)};
        `SHP_ADR_RXDATA: nxt_dat = {23'h000000, cnt_ff != '0,
                                    (cnt_ff != '0) ? mem[rp_ff] : 8'h00};
        `SHP_ADR_IRQ_STAT: nxt_dat = {26'h0000000, ist_ff};
        `SHP_ADR_IRQ_MASK: nxt_dat = {26'h0000000, imask_ff};
        default: nxt_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `SHP_CTRL_RST;
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
      ist_ff <= '0;
      imask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      irq_ff <= nxt_irq;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign txd_o = txd_ff;
  assign dtr_o = dtr_ff;
  assign irq_o = irq_ff;

endmodule // shp_serial_port

`default_nettype wire

// *** dv/shp_serial_port_chk.sv ***
// concurrent checks on the serial port's bus and line pins
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// checker
// ************************************************************
module shp_serial_port_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dsr_i,
  input wire logic txd_o,
  input wire logic dtr_o,
  input wire logic irq_o
);
  localparam int BIT_CLKS = 2592; // one bit at 9600 baud
  int fr_ff; // clocks left of the frame on the line
  logic txd_q; // line level one clock ago
  int lo_ff; // clocks of txd low in a row

  // run-length counters of the transmit line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fr_ff <= 0;
      txd_q <= 1'b1;
      lo_ff <= 0;
    end else begin
      txd_q <= txd_o;
      // a fall outside a frame opens one; ten bits cover its own falls
      fr_ff <= (txd_q && !txd_o && fr_ff == 0) ? 10 * BIT_CLKS :
               ((fr_ff > 0) ? fr_ff - 1 : 0);
      lo_ff <= txd_o ? 0 : lo_ff + 1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > 8'h18
      |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  property p_dat_hold;
    !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_reset_idle;
    $fell(rst_i) |-> txd_o && !dtr_o && !irq_o && !wb_ack_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bad reset");
  property p_dsr_gate;
    $fell(txd_o) && fr_ff == 0 |-> $past(dsr_i);
  endproperty
  a_dsr_gate: assert property (p_dsr_gate) else $error("sent on dsr low");
  property p_low_run;
    lo_ff <= 9 * BIT_CLKS + 2;
  endproperty
  a_low_run: assert property (p_low_run) else $error("line low too long");
endmodule // shp_serial_port_chk

bind shp_serial_port shp_serial_port_chk shp_serial_port_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dsr_i(dsr_i), .txd_o(txd_o), .dtr_o(dtr_o),
  .irq_o(irq_o));
`default_nettype wire

// *** dv/shp_host_model.sv ***
// controller model: sends frames on rxd, catches frames from txd
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// host model
// ************************************************************
module shp_host_model #(
  parameter int BIT_CLKS = 2592
) (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic dtr_i,
  output logic rxd_o,
  output logic dsr_o
);
  logic [7:0] rx_q[$]; // characters caught from the device
  logic [10:0] seen; // one captured frame, start first
  int n_bad; // frames with a bad start or stop bit

  initial begin
    rxd_o = 1'b1;
    dsr_o = 1'b1; // ready unless a test drops it
    n_bad = 0;
  end

  // readiness to take characters
  task automatic set_dsr(input logic v);
    @(posedge clk_i);
    dsr_o <= v;
  endtask

  // one eleven-bit frame, lsb first
  task automatic send_char(input logic [7:0] c, input logic ovr);
    logic [10:0] fr;
    int i;
    fr = {2'b11, c, 1'b0};
    // wait for go-ahead unless pushing a clear past it
    while (!ovr && dtr_i !== 1'b1) @(posedge clk_i);
    for (i = 0; i < 11; i++) begin
      @(posedge clk_i);
      rxd_o <= fr[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
  endtask

  // centre sampling of device frames; stops must be high
  always begin
    @(negedge txd_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      seen[i] = txd_i;
      if (i < 10) repeat (BIT_CLKS) @(posedge clk_i);
    end
    if (seen[10:9] != 2'b11 || seen[0]) n_bad++;
    rx_q.push_back(seen[8:1]);
  end
endmodule // shp_host_model
`default_nettype wire

// *** dv/shp_serial_port_tb_top.sv ***
// top testbench of the serial port
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// bench
// ************************************************************
module shp_serial_port_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rxd, dsr, txd_o, dtr_o, irq_o;
  int n_fail = 0;
  int checks_done = 0;
  int cyc_cnt = 0;

  always #20 clk_i = ~clk_i;

  shp_serial_port shp_serial_port_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd), .dsr_i(dsr),
    .txd_o(txd_o), .dtr_o(dtr_o), .irq_o(irq_o));
  shp_host_model shp_host_model_inst (.clk_i(clk_i), .txd_i(txd_o),
    .dtr_i(dtr_o), .rxd_o(rxd), .dsr_o(dsr));

  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one comparison
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic single wishbone cycle, released after sampled ack
  task automatic wb_cycle(input logic we, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // ack and read data are taken at the rising edge itself
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    check("ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask

  // read and compare the masked bits
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0, q);
    check(what, exp, q & m);
  endtask

  // let n edges pass, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // timeout ceiling
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 100000) begin
      n_fail++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", 8'h00, 32'hf, 32'h3);
    rd_chk("mask reset", 8'h18, 32'h3f, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    rd_chk("stat reset", 8'h04, 32'h10ff, 32'h0);
    for (int r = 0; r < 4; r++) begin
      wb_wr(8'h00, 32'(r));
      rd_chk("rate", 8'h00, 32'hf, 32'(r));
    end
    wb_wr(8'h00, 32'hf);
    wb_wr(8'h18, 32'h3f);
    // output held while the controller is not ready
    shp_host_model_inst.set_dsr(1'b0);
    wb_wr(8'h0c, 32'h141);
    settle(3000);
    check("txd held", 32'h1, {31'h0, txd_o});
    check("dtr suspended", 32'h0, {31'h0, dtr_o});
    wb_wr(8'h10, 32'h1);
    shp_host_model_inst.set_dsr(1'b1);
    shp_host_model_inst.send_char(8'h8a, 1'b0);
    settle(20);
    check("dtr talk", 32'h0, {31'h0, dtr_o});
    rd_chk("talk on", 8'h04, 32'h400, 32'h400);
    check("irq", 32'h1, {31'h0, irq_o});
    rd_chk("rx events", 8'h14, 32'h7, 32'h1);
    rd_chk("rx data", 8'h08, 32'h1ff, 32'h10a);
    wb_wr(8'h14, 32'h3f);
    settle(2);
    check("irq clear", 32'h0, {31'h0, irq_o});
    // response and its terminator
    for (int w = 0; w < 40000 && shp_host_model_inst.rx_q.size() < 2; w++)
      @(posedge clk_i);
    // host catches mid stop bit; done and release follow the frame end
    settle(1400);
    check("char", 32'hc1, {24'h0, shp_host_model_inst.rx_q[0]});
    check("newline", 32'h8a, {24'h0, shp_host_model_inst.rx_q[1]});
    check("frames", 32'h0, shp_host_model_inst.n_bad);
    rd_chk("done", 8'h14, 32'h10, 32'h10);
    rd_chk("talk off", 8'h04, 32'h400, 32'h0);
    check("dtr free", 32'h1, {31'h0, dtr_o});
    // clear character with output pending
    shp_host_model_inst.set_dsr(1'b0);
    wb_wr(8'h0c, 32'h055);
    shp_host_model_inst.send_char(8'h83, 1'b1);
    settle(20);
    rd_chk("slot flushed", 8'h04, 32'h1000, 32'h0);
    rd_chk("clear event", 8'h14, 32'h8, 32'h8);
    rd_chk("not stored", 8'h08, 32'h100, 32'h0);
    shp_host_model_inst.set_dsr(1'b1);
    settle(3000);
    check("no output", 32'h2, shp_host_model_inst.rx_q.size());
    give_verdict();
  end
endmodule // shp_serial_port_tb_top
`default_nettype wire
